// file: design/acsq_ctrl.v
// sample formatting, 32-entry sample queue and interrupt pin control
`timescale 1ns/100ps
`include "acsq_map.vh"

module acsq_ctrl (
    input  wire        clk_i,          // 40 mhz system clock
    input  wire        rstn_i,         // synchronous reset, active low
    input  wire [7:0]  addr_i,         // register address
    input  wire [7:0]  wdata_i,        // register write data
    input  wire        wr_i,           // write strobe
    input  wire        rd_i,           // read strobe
    output reg  [7:0]  rdata_o,        // read data, one cycle after rd_i
    input  wire        smp_valid_i,    // one-cycle pulse: new sample
    input  wire [13:0] smp_x_i,        // raw x result, two's complement
    input  wire [13:0] smp_y_i,        // raw y result
    input  wire [13:0] smp_z_i,        // raw z result
    input  wire        wake_evt_i,     // pulse: watch activity, moving to wake
    input  wire        awake_evt_i,    // pulse: activity while awake
    input  wire        watch_while_awake_mode_i, // level: combined mode active
    output wire [2:0]  span_sel_o,     // full-scale span code to front end
    output wire [2:0]  width_eff_o,    // effective width code in use
    output wire        irq_pin_o,      // irq pin output level
    output wire        irq_pin_oe_o    // irq pin output enable
);

    reg  [7:0]  scale_r;
    reg  [7:0]  qctl_r;
    reg  [7:0]  irqc_r;
    reg  [15:0] out_x_r;
    reg  [15:0] out_y_r;
    reg  [15:0] out_z_r;
    reg  [35:0] mem_r [0:`ACSQ_QDEPTH-1];
    reg  [4:0]  wptr_r;
    reg  [4:0]  rptr_r;
    reg  [5:0]  cnt_r;
    reg         new_r;
    reg         wake_r;
    reg         awake_r;
    reg  [3:0]  shift;
    reg  [2:0]  wcode;
    integer     i;

    wire        q_en    = qctl_r[`ACSQ_QEN_BIT];
    wire        q_clr   = qctl_r[`ACSQ_QCLR_BIT];
    wire        q_mode  = qctl_r[`ACSQ_QMODE_BIT];
    wire [4:0]  q_th    = qctl_r[`ACSQ_TH_MSB:`ACSQ_TH_LSB];

    // effective width: 14-bit code capped to 12 while queue enabled
    always @* begin
        wcode = scale_r[`ACSQ_WID_MSB:`ACSQ_WID_LSB];
        if (q_en && wcode == `ACSQ_W14) begin
            wcode = `ACSQ_W12;
        end
    end

    // right shift that keeps the top bits of the raw result
    always @* begin
        case (wcode)
            `ACSQ_W6:  shift = `ACSQ_SH6;
            `ACSQ_W7:  shift = `ACSQ_SH7;
            `ACSQ_W8:  shift = `ACSQ_SH8;
            `ACSQ_W10: shift = `ACSQ_SH10;
            `ACSQ_W12: shift = `ACSQ_SH12;
            default:   shift = `ACSQ_SH14; // reserved codes act as 14 bits
        endcase
    end

    assign width_eff_o = wcode;
    assign span_sel_o  = scale_r[`ACSQ_SPAN_MSB:`ACSQ_SPAN_LSB];

    // arithmetic shift then sign-extend to 16 bits
    wire signed [13:0] fx = $signed(smp_x_i) >>> shift;
    wire signed [13:0] fy = $signed(smp_y_i) >>> shift;
    wire signed [13:0] fz = $signed(smp_z_i) >>> shift;
    wire [15:0] sx = {{2{fx[13]}}, fx};
    wire [15:0] sy = {{2{fy[13]}}, fy};
    wire [15:0] sz = {{2{fz[13]}}, fz};

    // queue state
    wire        q_empty = (cnt_r == `ACSQ_QCNT_ZERO);
    wire        q_full  = (cnt_r == `ACSQ_QCNT_FULL);
    wire        q_lvl   = (cnt_r >= {1'b0, q_th});
    wire        q_stop  = q_mode && q_lvl;
    wire        q_push  = smp_valid_i && q_en && !q_clr && !q_full && !q_stop;
    wire        q_pop   = rd_i && (addr_i == `ACSQ_OFS_ZMSB) && q_en && !q_clr && !q_empty;
    wire [35:0] q_head  = mem_r[rptr_r];

    // flags shown to software: defaults while the queue is off
    wire        st_empty = q_en ? q_empty : 1'b1;
    wire        st_full  = q_en ? q_full  : 1'b0;
    wire        st_lvl   = q_en ? q_lvl   : 1'b0;
    wire        st_rd    = rd_i && (addr_i == `ACSQ_OFS_STAT);

    // control registers
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            scale_r <= `ACSQ_RST_REG;
            qctl_r  <= `ACSQ_RST_REG;
            irqc_r  <= `ACSQ_RST_REG;
        end else if (wr_i) begin
            case (addr_i)
                `ACSQ_OFS_SCALE: scale_r <= wdata_i & `ACSQ_SCALE_MASK;
                `ACSQ_OFS_QCTL:  qctl_r  <= wdata_i;
                `ACSQ_OFS_IRQC:  irqc_r  <= wdata_i;
                default:         scale_r <= scale_r;
            endcase
        end
    end

    // direct output registers, used while the queue is off
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            out_x_r <= `ACSQ_RST_SMP;
            out_y_r <= `ACSQ_RST_SMP;
            out_z_r <= `ACSQ_RST_SMP;
        end else if (smp_valid_i && !q_en) begin
            out_x_r <= sx;
            out_y_r <= sy;
            out_z_r <= sz;
        end
    end

    // queue storage, pointers and count; clear bit holds it at zero
    always @(posedge clk_i) begin
        if (!rstn_i || q_clr) begin
            wptr_r <= {`ACSQ_QAW{1'b0}};
            rptr_r <= {`ACSQ_QAW{1'b0}};
            cnt_r  <= `ACSQ_QCNT_ZERO;
            for (i = 0; i < `ACSQ_QDEPTH; i = i + 1) begin
                mem_r[i] <= 36'h000000000;
            end
        end else begin
            if (q_push) begin
                mem_r[wptr_r] <= {sx[11:0], sy[11:0], sz[11:0]};
                wptr_r        <= wptr_r + 5'h01;
            end
            if (q_pop) begin
                rptr_r <= rptr_r + 5'h01;
            end
            if (q_push && !q_pop) begin
                cnt_r <= cnt_r + 6'h01;
            end else if (q_pop && !q_push) begin
                cnt_r <= cnt_r - 6'h01;
            end
        end
    end

    // sticky event flags, cleared by a status read; a new event wins
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            new_r   <= 1'b0;
            wake_r  <= 1'b0;
            awake_r <= 1'b0;
        end else begin
            new_r   <= smp_valid_i || (new_r && !st_rd);
            wake_r  <= wake_evt_i || (wake_r && !st_rd);
            awake_r <= (awake_evt_i && watch_while_awake_mode_i)
                       || (awake_r && !st_rd);
        end
    end

    // irq sources gated by their enable bits; the queue sources also by the queue enable bit
    wire src_new   = irqc_r[`ACSQ_IRQ_NEW]   && new_r;
    wire src_wake  = irqc_r[`ACSQ_IRQ_WAKE]  && wake_r;
    wire src_awake = irqc_r[`ACSQ_IRQ_AWAKE] && awake_r;
    wire src_empty = irqc_r[`ACSQ_IRQ_EMPTY] && q_en && q_empty;
    wire src_full  = irqc_r[`ACSQ_IRQ_FULL]  && q_en && q_full;
    wire src_lvl   = irqc_r[`ACSQ_IRQ_LEVEL] && q_en && q_lvl;
    wire irq_act   = src_new | src_wake | src_awake | src_empty | src_full | src_lvl;

    // pin level from polarity; enable always on for push-pull, follows the inverted level for open drain
    wire pol       = irqc_r[`ACSQ_IRQ_POL];
    wire drv       = irqc_r[`ACSQ_IRQ_DRV];
    wire lvl       = pol ? irq_act : !irq_act;
    assign irq_pin_o    = drv ? lvl : 1'b0;
    assign irq_pin_oe_o = drv ? 1'b1 : !lvl;

    // data shown at the output offsets: queue head or direct registers
    wire [15:0] rd_x = q_en ? {{4{q_head[35]}}, q_head[35:24]} : out_x_r;
    wire [15:0] rd_y = q_en ? {{4{q_head[23]}}, q_head[23:12]} : out_y_r;
    wire [15:0] rd_z = q_en ? {{4{q_head[11]}}, q_head[11:0]}  : out_z_r;

    // read data, registered one cycle after the strobe
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_o <= `ACSQ_RST_REG;
        end else if (rd_i) begin
            case (addr_i)
                `ACSQ_OFS_XLSB:  rdata_o <= rd_x[7:0];
                `ACSQ_OFS_XMSB:  rdata_o <= rd_x[15:8];
                `ACSQ_OFS_YLSB:  rdata_o <= rd_y[7:0];
                `ACSQ_OFS_YMSB:  rdata_o <= rd_y[15:8];
                `ACSQ_OFS_ZLSB:  rdata_o <= rd_z[7:0];
                `ACSQ_OFS_ZMSB:  rdata_o <= rd_z[15:8];
                `ACSQ_OFS_STAT:  rdata_o <= {2'h0, awake_r, wake_r, st_lvl, st_full, st_empty, new_r};
                `ACSQ_OFS_COUNT: rdata_o <= {2'h0, q_en ? cnt_r : `ACSQ_QCNT_ZERO};
                `ACSQ_OFS_SCALE: rdata_o <= scale_r;
                `ACSQ_OFS_QCTL:  rdata_o <= qctl_r;
                `ACSQ_OFS_IRQC:  rdata_o <= irqc_r;
                default:         rdata_o <= `ACSQ_RST_REG;
            endcase
        end
    end

endmodule

// file: design/acsq_map.vh
// register map, field positions and codes for the sample queue and irq control
`ifndef ACSQ_MAP_VH
`define ACSQ_MAP_VH
// register offsets
`define ACSQ_OFS_XLSB    8'h02
`define ACSQ_OFS_XMSB    8'h03
`define ACSQ_OFS_YLSB    8'h04
`define ACSQ_OFS_YMSB    8'h05
`define ACSQ_OFS_ZLSB    8'h06
`define ACSQ_OFS_ZMSB    8'h07
`define ACSQ_OFS_STAT    8'h08
`define ACSQ_OFS_COUNT   8'h09
`define ACSQ_OFS_SCALE   8'h15
`define ACSQ_OFS_QCTL    8'h16
`define ACSQ_OFS_IRQC    8'h17
// reset values
`define ACSQ_RST_REG     8'h00
`define ACSQ_RST_SMP     16'h0000
// scale and width control fields
`define ACSQ_WID_MSB     2
`define ACSQ_WID_LSB     0
`define ACSQ_SPAN_MSB    6
`define ACSQ_SPAN_LSB    4
`define ACSQ_SCALE_MASK  8'h77
// sample width codes
`define ACSQ_W6          3'h0
`define ACSQ_W7          3'h1
`define ACSQ_W8          3'h2
`define ACSQ_W10         3'h3
`define ACSQ_W12         3'h4
`define ACSQ_W14         3'h5
// right shifts of the raw 14-bit result per width
`define ACSQ_SH6         4'h8
`define ACSQ_SH7         4'h7
`define ACSQ_SH8         4'h6
`define ACSQ_SH10        4'h4
`define ACSQ_SH12        4'h2
`define ACSQ_SH14        4'h0
// sample queue control fields
`define ACSQ_TH_MSB      4
`define ACSQ_TH_LSB      0
`define ACSQ_QMODE_BIT   5
`define ACSQ_QEN_BIT     6
`define ACSQ_QCLR_BIT    7
// irq source control fields
`define ACSQ_IRQ_DRV     0
`define ACSQ_IRQ_POL     1
`define ACSQ_IRQ_WAKE    2
`define ACSQ_IRQ_NEW     3
`define ACSQ_IRQ_EMPTY   4
`define ACSQ_IRQ_FULL    5
`define ACSQ_IRQ_LEVEL   6
`define ACSQ_IRQ_AWAKE   7
// status bits
`define ACSQ_ST_NEW      0
`define ACSQ_ST_EMPTY    1
`define ACSQ_ST_FULL     2
`define ACSQ_ST_LEVEL    3
`define ACSQ_ST_WAKE     4
`define ACSQ_ST_AWAKE    5
// queue geometry
`define ACSQ_QDEPTH      32
`define ACSQ_QCNT_FULL   6'd32
`define ACSQ_QCNT_ZERO   6'd0
`define ACSQ_QAW         5
`endif

// file: bench/acsq_host.sv
// host model: register port bus master
`timescale 1ns/100ps
module acsq_host (
    input  wire        clk_i,   // clock
    output logic [7:0] addr_o,  // address
    output logic [7:0] wdata_o, // write data
    output logic       wr_o,    // write strobe
    output logic       rd_o,    // read strobe
    input  wire  [7:0] rdata_i  // read data
);
    // idle bus at time zero
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // one-cycle write, address and data inverted once released
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask
    // one-cycle read, data taken in the following cycle
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1 d = rdata_i;
    endtask
endmodule

// file: bench/acsq_ctrl_checker.sv
// port checker for the sample queue and irq control block
`timescale 1ns/100ps
module acsq_chk (
    input wire       clk_i,        // clock
    input wire       rstn_i,       // reset, active low
    input wire [7:0] addr_i,       // address
    input wire [7:0] wdata_i,      // write data
    input wire       wr_i,         // write strobe
    input wire       smp_valid_i,  // sample pulse
    input wire       wake_evt_i,   // wake pulse
    input wire [2:0] span_sel_o,   // span code
    input wire [2:0] width_eff_o,  // width code
    input wire       irq_pin_o,    // pin level
    input wire       irq_pin_oe_o  // pin enable
);
    reg  [7:0] irqc_r;
    wire       wr_irqc = wr_i && addr_i == 8'h17;
    wire       lvl = irqc_r[0] ? irq_pin_o : !irq_pin_oe_o;
    // shadow of the irq control register
    always @(posedge clk_i) begin
        if (!rstn_i) irqc_r <= 8'h00;
        else if (wr_irqc) irqc_r <= wdata_i;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_span_field: assert property (wr_i && addr_i == 8'h15 |=> span_sel_o == $past(wdata_i[6:4]))
        else $error("span code not taken from write");
    a_width_code: assert property (wr_i && addr_i == 8'h15 && wdata_i[2:0] < 3'h5 |=> width_eff_o == $past(wdata_i[2:0]))
        else $error("width code not taken from write");
    a_width_queue: assert property (wr_i && addr_i == 8'h16 && wdata_i[6] && width_eff_o == 3'h5 |=> width_eff_o == 3'h4)
        else $error("width not limited with queue on");
    a_open_drain: assert property (!irqc_r[0] |-> !irq_pin_o)
        else $error("open drain pin driven high");
    a_push_pull: assert property (irqc_r[0] |-> irq_pin_oe_o)
        else $error("push pull pin not driven");
    a_idle_level: assert property (irqc_r[7:2] == 6'h00 |-> irq_pin_o == (irqc_r[0] & !irqc_r[1]) && irq_pin_oe_o == (irqc_r[0] | irqc_r[1]))
        else $error("idle pin level wrong");
    a_new_irq: assert property (irqc_r[3] && smp_valid_i && !wr_irqc |=> lvl == irqc_r[1])
        else $error("no irq on new sample");
    a_wake_irq: assert property (irqc_r[2] && wake_evt_i && !wr_irqc |=> lvl == irqc_r[1])
        else $error("no irq on wake event");
endmodule
bind acsq_ctrl acsq_chk acsq_chk_i (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .smp_valid_i(smp_valid_i), .wake_evt_i(wake_evt_i), .span_sel_o(span_sel_o), .width_eff_o(width_eff_o),
    .irq_pin_o(irq_pin_o), .irq_pin_oe_o(irq_pin_oe_o));

// file: bench/tb.sv
// self-checking bench for the sample queue and irq control block
`timescale 1ns/100ps
module tb;
    logic        clk_i = 1'b0, rstn_i = 1'b0, smp_valid_i = 1'b0, wake_evt_i = 1'b0, awake_evt_i = 1'b0, wwa_i = 1'b0;
    logic [13:0] smp_x_i = 14'h0000;
    logic [7:0]  addr_i, wdata_i, rdata_o, rv, rh;
    logic        wr_i, rd_i, irq_pin_o, irq_pin_oe_o;
    logic [2:0]  span_sel_o, width_eff_o;
    int          err_count = 0, n_tests = 0;
    int          sh[6] = '{8, 7, 6, 4, 2, 0};
    initial forever #12.5 clk_i = ~clk_i;
    acsq_host acsq_host_i (.clk_i(clk_i), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o));
    acsq_ctrl acsq_ctrl_i (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .smp_valid_i(smp_valid_i), .smp_x_i(smp_x_i), .smp_y_i(~smp_x_i),
        .smp_z_i(smp_x_i), .wake_evt_i(wake_evt_i), .awake_evt_i(awake_evt_i), .watch_while_awake_mode_i(wwa_i),
        .span_sel_o(span_sel_o), .width_eff_o(width_eff_o), .irq_pin_o(irq_pin_o), .irq_pin_oe_o(irq_pin_oe_o));
    task chk(string nm, logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task smp(logic [13:0] x);
        @(posedge clk_i);
        smp_valid_i <= 1'b1;
        smp_x_i <= x;
        @(posedge clk_i);
        smp_valid_i <= 1'b0;
    endtask
    task ev(bit w, bit m);
        @(posedge clk_i);
        wake_evt_i <= w;
        awake_evt_i <= !w;
        wwa_i <= m;
        @(posedge clk_i);
        wake_evt_i <= 1'b0;
        awake_evt_i <= 1'b0;
        #1;
    endtask
    task pin(logic [1:0] e);
        chk("pin oe,out", {irq_pin_oe_o, irq_pin_o}, e);
    endtask
    task t_format;
        logic signed [15:0] e;
        for (int a = 8'h15; a <= 8'h17; a++) begin
            acsq_host_i.rd(a[7:0], rv);
            chk("reset value", rv, 8'h00);
        end
        foreach (sh[i]) begin
            acsq_host_i.wr(8'h15, 8'h40 | i[7:0]);
            #1 chk("width", width_eff_o, i[2:0]);
            chk("span", span_sel_o, 3'h4);
            smp(14'h2a5c);
            acsq_host_i.rd(8'h02, rv);
            acsq_host_i.rd(8'h03, rh);
            e = $signed(16'hea5c) >>> sh[i];
            chk("x data", {rh, rv}, e);
        end
        $display("test format done");
    endtask
    task t_queue;
        acsq_host_i.wr(8'h15, 8'h05);
        acsq_host_i.wr(8'h16, 8'h63);
        #1 chk("width queued", width_eff_o, 3'h4);
        acsq_host_i.wr(8'h17, 8'h43);
        repeat (5) smp(14'h0123);
        acsq_host_i.rd(8'h09, rv);
        chk("watermark count", rv, 8'h03);
        pin(2'b11);
        acsq_host_i.rd(8'h02, rv);
        acsq_host_i.rd(8'h03, rh);
        chk("queue head", {rh, rv}, 16'h0048);
        acsq_host_i.wr(8'h16, 8'hc0);
        acsq_host_i.rd(8'h09, rv);
        chk("cleared count", rv, 8'h00);
        acsq_host_i.wr(8'h17, 8'h23);
        acsq_host_i.wr(8'h16, 8'h40);
        repeat (33) smp(14'h0123);
        acsq_host_i.rd(8'h09, rv);
        chk("full count", rv, 8'h20);
        pin(2'b11);
        acsq_host_i.wr(8'h17, 8'h13);
        acsq_host_i.wr(8'h16, 8'hc0);
        acsq_host_i.wr(8'h16, 8'h40);
        #1 pin(2'b11);
        acsq_host_i.wr(8'h16, 8'h00);
        #1 pin(2'b10);
        acsq_host_i.rd(8'h08, rv);
        chk("flags queue off", rv, 8'h03);
        $display("test queue done");
    endtask
    task t_irq;
        acsq_host_i.wr(8'h17, 8'h08);
        acsq_host_i.rd(8'h08, rv);
        pin(2'b00);
        smp(14'h0001);
        #1 pin(2'b10);
        acsq_host_i.wr(8'h17, 8'h86);
        acsq_host_i.rd(8'h08, rv);
        pin(2'b10);
        ev(1'b0, 1'b0);
        pin(2'b10);
        ev(1'b0, 1'b1);
        pin(2'b00);
        acsq_host_i.rd(8'h08, rv);
        ev(1'b1, 1'b0);
        pin(2'b00);
        $display("test irq done");
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_format;
        t_queue;
        t_irq;
        close_out;
    end
    initial begin
        #1000000;
        err_count++;
        close_out;
    end
endmodule
